// ### logic/current_wiring_supervision.sv
`timescale 1ns/1ps
`default_nettype none
`include "cts_params.svh"
module current_wiring_supervision
   import cts_pkg::*;
#(
   parameter int MS_CYCLES = `MS_CYCLES,
   parameter int LOG_DEPTH = `LOG_DEPTH
) (
   input wire logic mclk_i, // 25 MHz clock
   input wire logic reset_i, // Sync reset, active high
   input wire logic eval_i, // Program cycle strobe
   input wire logic block_i, // Blocking matrix input
   input wire meas_t meas_i, // Measured magnitudes
   input wire diff_t diff_i, // Residual comparison values
   input wire set_t set_i, // Active setting group
   input wire logic [3:0] evt_mask_i, // Store enable per event
   input wire logic cnt_clr_i, // Clear cumulative counter
   input wire logic [3:0] log_idx_i, // Log slot, 0 is newest
   output logic start_o, // Start indication
   output logic alarm_o, // Alarm indication
   output logic blocked_o, // Blocked indication
   output logic evt_valid_o, // Event pulse
   output evt_t evt_code_o, // Event identifier
   output logic [39:0] evt_stamp_o, // Event time in ms
   output logic [15:0] cnt_o, // Cumulative counter
   output logic [21:0] remain_o, // Time to alarm, ms
   output diff_t diff_o, // Residual difference status
   output rec_t log_rec_o // Selected log record
);

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (reset_i);

   // Scale a limit by a percentage for hysteresis
   function automatic logic [15:0] scale(input logic [15:0] v,
                                         input logic [7:0] pct);
      logic [23:0] p;
      p = v * pct / 8'(`PCT_FULL);
      return p[15:0];
   endfunction : scale

   // a * b <= c * d without overflow
   function automatic logic mul_le(input logic [15:0] a,
                                   input logic [13:0] b,
                                   input logic [15:0] c,
                                   input logic [13:0] d);
      return (30'(a) * 30'(b)) <= (30'(c) * 30'(d));
   endfunction : mul_le

   state_t state_r, state_nxt;
   logic eval_d_r;
   logic blk_s_r;
   meas_t meas_r;
   logic [15:0] imax, imin;
   logic [15:0] hi_lim, lo_lim, res_lim;
   logic over_hi, above_lo, ratio_ok, neg_ok, res_ok, pickup;
   logic [4:0] fault;
   logic [21:0] tmr_r;
   logic [31:0] pre_r;
   logic ms_tick;
   logic [39:0] now_r;
   logic ev_aon, ev_aoff, ev_bon, ev_boff;
   rec_t log_mem [LOG_DEPTH];
   logic [3:0] wr_ptr_r;
   logic [3:0] rd_slot;

   // Blocking and measurements frozen at cycle start
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         eval_d_r <= 1'b0;
         blk_s_r <= 1'b0;
         meas_r <= '0;
      end else begin
         eval_d_r <= eval_i;
         if (eval_i) begin
            blk_s_r <= block_i;
            meas_r <= meas_i;
         end
      end
   end

   // Largest and smallest phase
   always_comb begin
      imax = meas_r.ph1;
      imin = meas_r.ph1;
      if (meas_r.ph2 > imax) imax = meas_r.ph2;
      if (meas_r.ph3 > imax) imax = meas_r.ph3;
      if (meas_r.ph2 < imin) imin = meas_r.ph2;
      if (meas_r.ph3 < imin) imin = meas_r.ph3;
   end

   // Limits widen once picked up so a marginal input cannot chatter
   always_comb begin
      if (state_r == ST_IDLE) begin
         hi_lim = set_i.hi_limit;
         lo_lim = set_i.lo_limit;
         res_lim = set_i.sum_diff;
      end else begin
         hi_lim = scale(set_i.hi_limit, 8'(`HYST_HIGH_PCT));
         lo_lim = scale(set_i.lo_limit, 8'(`HYST_LOW_PCT));
         res_lim = scale(set_i.sum_diff, 8'(`HYST_LOW_PCT));
      end
   end

   // Pick-up conditions; all must hold together
   always_comb begin
      over_hi = imax > hi_lim;
      above_lo = imax >= lo_lim;
      ratio_ok = mul_le(imin, 14'(`RATIO_FULL), imax, set_i.ratio);
      neg_ok = mul_le(meas_r.positive_sequence_current, set_i.neg_ratio,
                      meas_r.negative_sequence_current,
                      14'(`RATIO_FULL));
      res_ok = (set_i.res_sel == RES_NONE) ||
               (diff_i.diff_mag >= res_lim);
      pickup = !over_hi && above_lo && ratio_ok && neg_ok && res_ok;
      fault = {over_hi, above_lo, ratio_ok, neg_ok, res_ok};
   end

   // Millisecond time base for timer and stamps
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         pre_r <= '0;
         now_r <= '0;
      end else if (pre_r == 32'(MS_CYCLES - 1)) begin
         pre_r <= '0;
         now_r <= now_r + 40'h1;
      end else begin
         pre_r <= pre_r + 32'h1;
      end
   end
   assign ms_tick = (pre_r == 32'(MS_CYCLES - 1));

   // Supervision state, decided once per evaluation
   always_comb begin
      state_nxt = state_r;
      if (eval_d_r) begin
         case (state_r)
            ST_IDLE: begin
               if (pickup && blk_s_r) state_nxt = ST_BLOCKED;
               else if (pickup) state_nxt = ST_RUN;
            end
            ST_RUN: begin
               // Block or dropout both run the release path
               if (blk_s_r || !pickup) state_nxt = ST_IDLE;
               else if (tmr_r == '0) state_nxt = ST_ALARM;
            end
            ST_ALARM: begin
               if (blk_s_r || !pickup) state_nxt = ST_IDLE;
            end
            ST_BLOCKED: begin
               if (!blk_s_r || !pickup) state_nxt = ST_IDLE;
            end
            default: state_nxt = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) state_r <= ST_IDLE;
      else state_r <= state_nxt;
   end

   // Event edges of the outputs
   always_comb begin
      ev_aon = state_nxt == ST_ALARM && state_r != ST_ALARM;
      ev_aoff = state_nxt != ST_ALARM && state_r == ST_ALARM;
      ev_bon = state_nxt == ST_BLOCKED && state_r != ST_BLOCKED;
      ev_boff = state_nxt != ST_BLOCKED && state_r == ST_BLOCKED;
   end

   // Indications
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         start_o <= 1'b0;
         alarm_o <= 1'b0;
         blocked_o <= 1'b0;
      end else begin
         start_o <= state_nxt == ST_RUN || state_nxt == ST_ALARM;
         alarm_o <= state_nxt == ST_ALARM;
         blocked_o <= state_nxt == ST_BLOCKED;
      end
   end

   // Fixed delay only: no curve, the setting counts DELAY_STEP_MS steps
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         tmr_r <= `TMR_RESET;
      end else if (state_r == ST_IDLE && state_nxt == ST_RUN) begin
         tmr_r <= 22'(set_i.definite_time_delay
                      * `DELAY_STEP_MS);
      end else if (state_nxt == ST_IDLE) begin
         tmr_r <= `TMR_RESET;
      end else if (state_r == ST_RUN && ms_tick && tmr_r != '0) begin
         tmr_r <= tmr_r - 22'h1;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) remain_o <= `TMR_RESET;
      else remain_o <= tmr_r;
   end

   // Masked event stream; one edge per cycle at most
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         evt_valid_o <= 1'b0;
         evt_code_o <= EV_ALARM_ON;
         evt_stamp_o <= '0;
      end else begin
         evt_valid_o <= 1'b0;
         evt_stamp_o <= now_r;
         if (ev_aon && evt_mask_i[EV_ALARM_ON]) begin
            evt_valid_o <= 1'b1;
            evt_code_o <= EV_ALARM_ON;
         end else if (ev_aoff && evt_mask_i[EV_ALARM_OFF]) begin
            evt_valid_o <= 1'b1;
            evt_code_o <= EV_ALARM_OFF;
         end else if (ev_bon && evt_mask_i[EV_BLOCK_ON]) begin
            evt_valid_o <= 1'b1;
            evt_code_o <= EV_BLOCK_ON;
         end else if (ev_boff && evt_mask_i[EV_BLOCK_OFF]) begin
            evt_valid_o <= 1'b1;
            evt_code_o <= EV_BLOCK_OFF;
         end
      end
   end

   // Counter; a clear in the same cycle as a new event restarts the count at 1
   always_ff @(posedge mclk_i) begin
      if (reset_i) cnt_o <= `CNT_RESET;
      else if (ev_aon || ev_bon) begin
         cnt_o <= cnt_clr_i ? 16'h1 : cnt_o + 16'h1;
      end else if (cnt_clr_i) cnt_o <= `CNT_RESET;
   end

   // Rolling log written on the on events only
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         wr_ptr_r <= '0;
      end else if (ev_aon || ev_bon) begin
         log_mem[wr_ptr_r] <= '{stamp_ms: now_r,
                                evt: ev_aon ? EV_ALARM_ON : EV_BLOCK_ON,
                                trig: meas_r, remain_ms: tmr_r,
                                fault: fault,
                                group: set_i.group};
         wr_ptr_r <= (wr_ptr_r == 4'(LOG_DEPTH - 1)) ?
                     4'h0 : wr_ptr_r + 4'h1;
      end
   end

   // Newest record at index 0; slots never written read as junk
   always_comb begin
      if (wr_ptr_r > log_idx_i) rd_slot = wr_ptr_r - log_idx_i - 4'h1;
      else rd_slot = 4'(LOG_DEPTH) + wr_ptr_r - log_idx_i - 4'h1;
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) log_rec_o <= '0;
      else if (log_idx_i < 4'(LOG_DEPTH)) log_rec_o <= log_mem[rd_slot];
      else log_rec_o <= '0;
   end

   // Live status values, refreshed every clock
   always_ff @(posedge mclk_i) begin
      if (reset_i) diff_o <= '0;
      else diff_o <= diff_i;
   end

   // Blocking seen during start drops the start indication
   a_start_clear: assert property (
      eval_d_r && blk_s_r && state_r == ST_RUN |=> !start_o && !alarm_o)
      else $error("start not cleared by blocking");

   a_start_unblocked: assert property (
      $rose(start_o) |-> !$past(blk_s_r) && $past(eval_d_r))
      else $error("start raised while blocked");

   a_blocked_quiet: assert property (
      blocked_o |-> !alarm_o && !start_o && tmr_r == '0)
      else $error("timing active while blocked");

   a_alarm_expiry: assert property (
      $rose(alarm_o) |-> $past(tmr_r) == '0 && $past(state_r) == ST_RUN)
      else $error("alarm before delay expired");

   a_high_suppress: assert property (
      eval_d_r && state_r == ST_IDLE && over_hi |=> !start_o && !blocked_o)
      else $error("activation above upper limit");

   a_low_suppress: assert property (
      eval_d_r && state_r == ST_IDLE && !above_lo |=> !start_o)
      else $error("activation below lower limit");

   a_residual_gate: assert property (
      eval_d_r && state_r == ST_IDLE && set_i.res_sel != RES_NONE
      && diff_i.diff_mag < set_i.sum_diff |=> !start_o)
      else $error("activation with small residual difference");

   a_dropout_reset: assert property (
      eval_d_r && state_r == ST_RUN && !pickup
      |=> state_r == ST_IDLE && tmr_r == '0 ##1 !alarm_o)
      else $error("timer not reset on dropout");

   a_count_step: assert property (
      $rose(alarm_o) && !$past(cnt_clr_i)
      |-> cnt_o == $past(cnt_o) + 16'h1)
      else $error("counter missed alarm");

   // Alarm on reaches the event stream only when its mask bit is set
   a_alarm_event: assert property (
      $rose(alarm_o) |-> evt_valid_o == (($past(evt_mask_i) & 4'h1) != 4'h0)
      && (!evt_valid_o || evt_code_o == EV_ALARM_ON))
      else $error("alarm on event not stored as masked");

   a_log_advance: assert property (
      ev_aon || ev_bon |=> wr_ptr_r != $past(wr_ptr_r)
      && wr_ptr_r < 4'(LOG_DEPTH))
      else $error("log pointer did not advance");

endmodule : current_wiring_supervision
`default_nettype wire

// ### shared/cts_params.svh
`ifndef CTS_PARAMS_SVH
`define CTS_PARAMS_SVH
// Clock and time base
`define CLK_PERIOD_NS 40
`define MS_IN_NS 1000000
`define MS_CYCLES (`MS_IN_NS / `CLK_PERIOD_NS)
// Alarm delay step and blocking lead time, in ms
`define DELAY_STEP_MS 5
`define BLOCK_LEAD_MS 5
// Release hysteresis in percent of the pick-up limit
`define HYST_LOW_PCT 97
`define HYST_HIGH_PCT 103
`define PCT_FULL 100
// Ratio settings in 0.01 % units: full scale 100.00 %
`define RATIO_FULL 10000
// Activation log
`define LOG_DEPTH 12
// Reset values
`define CNT_RESET 16'h0000
`define TMR_RESET 22'h000000
`endif

// ### shared/cts_pkg.sv
`default_nettype none
package cts_pkg;
   // Current magnitudes in 0.01 xIn, one per measured quantity
   typedef struct packed {
      logic [15:0] ph1;
      logic [15:0] ph2;
      logic [15:0] ph3;
      logic [15:0] residual_input_one;
      logic [15:0] residual_input_two;
      logic [15:0] positive_sequence_current;
      logic [15:0] negative_sequence_current;
   } meas_t;

   // Summed against measured residual, 0.01 xIn and 0.01 deg
   typedef struct packed {
      logic [15:0] diff_mag;
      logic signed [16:0] diff_ang;
      logic signed [16:0] nat_ang;
   } diff_t;

   typedef enum logic [1:0] {RES_NONE, RES_ONE, RES_TWO} res_sel_t;

   // Active setting group values
   typedef struct packed {
      logic [15:0] hi_limit;
      logic [15:0] lo_limit;
      logic [13:0] ratio;
      logic [13:0] neg_ratio;
      logic [15:0] sum_diff;
      logic [18:0] definite_time_delay;
      res_sel_t res_sel;
      logic [2:0] group;
   } set_t;

   typedef enum logic [1:0] {
      EV_ALARM_ON, EV_ALARM_OFF, EV_BLOCK_ON, EV_BLOCK_OFF
   } evt_t;

   typedef enum {ST_IDLE, ST_RUN, ST_ALARM, ST_BLOCKED} state_t;

   // One activation record
   typedef struct packed {
      logic [39:0] stamp_ms;
      evt_t evt;
      meas_t trig;
      logic [21:0] remain_ms;
      logic [4:0] fault;
      logic [2:0] group;
   } rec_t;
endpackage : cts_pkg
`default_nettype wire

// ### verification/cts_block_partner.sv
`timescale 1ns/1ps
`default_nettype none
module cts_block_partner
   import cts_pkg::*;
(
   input wire logic mclk_i, // Relay clock
   input wire logic reset_i, // Sync reset, active high
   input wire logic block_req_i, // Wanted blocking level
   input wire logic evt_valid_i, // Event pulse from block
   input wire evt_t evt_code_i, // Event identifier
   output logic block_o, // Blocking matrix output
   output logic [31:0] tally_o // Stored events, 8 bits per code
);
   // Start unblocked so the block never sees an unknown level
   initial block_o = 1'b0;

   // Blocking matrix: follows the request one cycle late, and the bench
   // raises it whole milliseconds ahead of any alarm expiry
   always @(posedge mclk_i) begin
      #1;
      block_o = block_req_i;
   end

   // Event buffer: counts each stored event code
   always @(posedge mclk_i) begin
      if (reset_i) begin
         tally_o <= 32'h00000000;
      end else if (evt_valid_i) begin
         tally_o[8*evt_code_i +: 8] <= tally_o[8*evt_code_i +: 8] + 8'h01;
      end
   end
endmodule : cts_block_partner
`default_nettype wire

// ### verification/test_current_wiring_supervision.sv
`timescale 1ns/1ps
`default_nettype none
module test_current_wiring_supervision;
   import cts_pkg::*;
   localparam int MSC = 4;
   logic mclk_i = 1'b0;
   logic reset_i = 1'b1;
   logic eval_i = 1'b0;
   logic eval_en = 1'b0;
   logic block_req = 1'b0;
   logic block_i;
   meas_t meas_i = '0;
   diff_t diff_i = '0;
   set_t set_i = '0;
   logic [3:0] evt_mask_i = 4'hF;
   logic cnt_clr_i = 1'b0;
   logic [3:0] log_idx_i = 4'h0;
   logic start_o, alarm_o, blocked_o, evt_valid_o;
   evt_t evt_code_o;
   logic [39:0] evt_stamp_o;
   logic [15:0] cnt_o;
   logic [21:0] remain_o;
   diff_t diff_o;
   rec_t log_rec_o;
   logic [31:0] tally;
   int err_count = 0;
   int total_checks = 0;
   int cyc = 0;
   int n;

   // Clock, 40 ns period
   always #20 mclk_i = ~mclk_i;

   // Program cycle strobe, one every 4 clocks (1 ms at the short tick)
   always @(posedge mclk_i) begin
      #1;
      cyc = cyc + 1;
      eval_i = eval_en && (cyc % 4 == 0);
   end

   current_wiring_supervision #(.MS_CYCLES(MSC), .LOG_DEPTH(12))
      i_current_wiring_supervision (.mclk_i(mclk_i), .reset_i(reset_i),
      .eval_i(eval_i), .block_i(block_i), .meas_i(meas_i),
      .diff_i(diff_i), .set_i(set_i), .evt_mask_i(evt_mask_i),
      .cnt_clr_i(cnt_clr_i), .log_idx_i(log_idx_i), .start_o(start_o),
      .alarm_o(alarm_o), .blocked_o(blocked_o), .evt_valid_o(evt_valid_o),
      .evt_code_o(evt_code_o), .evt_stamp_o(evt_stamp_o), .cnt_o(cnt_o),
      .remain_o(remain_o), .diff_o(diff_o), .log_rec_o(log_rec_o));

   cts_block_partner i_cts_block_partner (.mclk_i(mclk_i),
      .reset_i(reset_i), .block_req_i(block_req),
      .evt_valid_i(evt_valid_o), .evt_code_i(evt_code_o),
      .block_o(block_i), .tally_o(tally));

   task automatic results();
      if (err_count == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : results

   task automatic check(input string name, input logic [127:0] seen,
                        input logic [127:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %0h seen %0h", name, exp, seen);
      end
   endtask : check

   task automatic step(input int k);
      repeat (k) @(posedge mclk_i);
      #1;
   endtask : step

   function automatic logic ind(input int w);
      case (w)
         0: return start_o;
         1: return alarm_o;
         default: return blocked_o;
      endcase
   endfunction : ind

   // Bounded wait on an indication; a hang counts as a mismatch
   task automatic wait_for(input int w, input logic v, input int lim,
                           output int k);
      for (k = 1; k <= lim; k++) begin
         step(1);
         if (ind(w) === v) return;
      end
      err_count++;
      $display("mismatch wait indication %0d expected %0h", w, v);
      results();
   endtask : wait_for

   // Phases, then negative sequence; positive sequence held at 0.57
   task automatic set_meas(input logic [15:0] a, input logic [15:0] b,
                           input logic [15:0] c, input logic [15:0] neg);
      meas_i.ph1 = a;
      meas_i.ph2 = b;
      meas_i.ph3 = c;
      meas_i.positive_sequence_current = 16'h0039;
      meas_i.negative_sequence_current = neg;
   endtask : set_meas

   task automatic healthy();
      set_meas(16'h0064, 16'h0064, 16'h0064, 16'h0000);
   endtask : healthy

   task automatic fault();
      set_meas(16'h0000, 16'h0064, 16'h0064, 16'h0020);
   endtask : fault

   task automatic t_suppress();
      set_meas(16'h0000, 16'h00C8, 16'h0064, 16'h0020);
      step(24);
      check("start over high", start_o, 1'b0);
      set_meas(16'h0000, 16'h0005, 16'h0005, 16'h0020);
      step(24);
      check("start under low", start_o, 1'b0);
      fault();
      set_i.res_sel = RES_ONE;
      diff_i.diff_mag = 16'h0000;
      step(24);
      check("start small diff", start_o, 1'b0);
      diff_i.diff_mag = 16'h0032;
      wait_for(0, 1'b1, 12, n);
      healthy();
      wait_for(0, 1'b0, 12, n);
      set_i.res_sel = RES_NONE;
   endtask : t_suppress

   task automatic t_alarm();
      logic [39:0] ts;
      fault();
      wait_for(0, 1'b1, 12, n);
      wait_for(1, 1'b1, 60, n);
      check("alarm delay", n >= 36 && n <= 48, 1'b1);
      check("alarm event", evt_valid_o, 1'b1);
      check("alarm code", evt_code_o, EV_ALARM_ON);
      ts = evt_stamp_o;
      step(2);
      check("log remain", log_rec_o.remain_ms, 22'h000000);
      check("log fault", log_rec_o.fault, 5'h0F);
      check("count alarm", cnt_o, 16'h0001);
      check("log event", log_rec_o.evt, EV_ALARM_ON);
      check("log group", log_rec_o.group, 3'h3);
      check("log trig", log_rec_o.trig, meas_i);
      healthy();
      wait_for(1, 1'b0, 12, n);
      check("alarm off code", evt_code_o, EV_ALARM_OFF);
      check("alarm off stamp", evt_stamp_o, ts + 40'h1);
      step(2);
      check("alarm off stored", tally[15:8], 8'h01);
   endtask : t_alarm

   task automatic t_dropout();
      fault();
      wait_for(0, 1'b1, 12, n);
      step(2);
      check("remain loaded", remain_o, 22'h00000A);
      step(14);
      healthy();
      wait_for(0, 1'b0, 12, n);
      step(60);
      check("no alarm drop", tally[7:0], 8'h01);
   endtask : t_dropout

   task automatic t_block_start();
      fault();
      wait_for(0, 1'b1, 12, n);
      step(8);
      block_req = 1'b1;
      wait_for(0, 1'b0, 12, n);
      step(60);
      check("alarm under block", alarm_o, 1'b0);
      check("blocked after start", blocked_o, 1'b1);
      healthy();
      step(8);
      block_req = 1'b0;
      step(8);
   endtask : t_block_start

   task automatic t_blocked();
      evt_mask_i = 4'hB;
      block_req = 1'b1;
      step(8);
      fault();
      wait_for(2, 1'b1, 12, n);
      step(60);
      check("start blocked", start_o, 1'b0);
      check("alarm blocked", alarm_o, 1'b0);
      check("count blocked", cnt_o, 16'h0003);
      check("masked block on", tally[23:16], 8'h01);
      check("log blocked", log_rec_o.evt, EV_BLOCK_ON);
      block_req = 1'b0;
      wait_for(2, 1'b0, 12, n);
      step(2);
      check("block off stored", tally[31:24], 8'h02);
      healthy();
      evt_mask_i = 4'hF;
      step(8);
   endtask : t_blocked

   task automatic t_status();
      diff_i = {16'h0123, 17'h1FF00, 17'h08CA0};
      step(2);
      check("diff status", diff_o, diff_i);
      cnt_clr_i = 1'b1;
      step(1);
      cnt_clr_i = 1'b0;
      step(1);
      check("count cleared", cnt_o, 16'h0000);
      log_idx_i = 4'h2;
      step(2);
      check("log oldest", log_rec_o.evt, EV_ALARM_ON);
      log_idx_i = 4'hC;
      step(2);
      check("log past end", log_rec_o == '0, 1'b1);
      log_idx_i = 4'h0;
   endtask : t_status

   // Main sequence: reset, settings, then each scenario in turn
   initial begin
      set_i.hi_limit = 16'h0078;
      set_i.lo_limit = 16'h000A;
      set_i.ratio = 14'h03E8;
      set_i.neg_ratio = 14'h1324;
      set_i.sum_diff = 16'h000A;
      set_i.definite_time_delay = 19'h00002;
      set_i.res_sel = RES_NONE;
      set_i.group = 3'h3;
      healthy();
      step(2);
      check("reset start", {start_o, alarm_o, blocked_o}, 3'h0);
      check("reset count", cnt_o, 16'h0000);
      reset_i = 1'b0;
      eval_en = 1'b1;
      step(24);
      check("healthy start", start_o, 1'b0);
      t_suppress();
      t_alarm();
      t_dropout();
      t_block_start();
      t_blocked();
      t_status();
      results();
   end
endmodule : test_current_wiring_supervision
`default_nettype wire
